// ### hdl/asbir_front.sv
`timescale 1ns/1ps
module asbir_front
    import asbir_pkg::*;
(
    input  wire logic        clk_sys,         // 100 MHz bus clock
    input  wire logic        reset_n,         // Async reset, active low
    input  wire logic [2:0]  address,         // Register index
    input  wire logic        read,            // Avalon read
    input  wire logic        write,           // Avalon write
    input  wire logic [3:0]  byteenable,      // Only lane 0 used
    input  wire logic [31:0] writedata,       // Write data
    output logic [31:0]      readdata,        // Read data, low byte used
    output logic             waitrequest,     // Stall the master
    input  wire logic        rxdIn,           // Receive pin
    output logic             txdOut,          // Transmit pin level
    output logic             txdOe,           // Transmit pin enable
    output logic             sampleTick       // Sixteen per bit
);

    // Decodes a pulse select to its width in 1/32 bit units
    function automatic logic [5:0] pulseWidth(input logic [1:0] sel);
        case (sel)
            2'b11:   pulseWidth = PULSE_1_4; // see [R7]
            2'b10:   pulseWidth = PULSE_1_32;
            2'b01:   pulseWidth = PULSE_1_16;
            default: pulseWidth = PULSE_3_16;
        endcase
    endfunction

    asbir_baud_cfg_type cfg_q, cfg_d;
    logic [7:0]  highHold_q, highHold_d;
    logic [7:0]  frame_q, frame_d, enable_q, enable_d, map_q, map_d;
    logic [7:0]  altLine_q, altLine_d, altIrq_q, altIrq_d;
    logic [7:0]  altBerr_q, altBerr_d, ninth_q, ninth_d;
    logic [7:0]  rxData_q, rxData_d;
    logic        rxFull_q, rxFull_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        started_q, started_d;
    logic        altMap, txEn, rxEn, wrEn, rdEn, bufInReady, dataBlocked;

    assign altMap = map_q[BIT_ALT_MAP];
    assign txEn   = enable_q[BIT_TX_EN];
    assign rxEn   = enable_q[BIT_RX_EN];

    // One wait cycle per access; a data write also waits for buffer room
    assign dataBlocked = write && address == IDX_DATA && byteenable[0]
                         && !bufInReady;
    assign waitrequest = (read || write) && !ack_q;
    assign wrEn        = write && ack_q && byteenable[0];
    assign rdEn        = read && ack_q;
    assign readdata    = rdata_q;

    // Baud generator
    logic [12:0] baudCnt_q, baudCnt_d;
    logic        halfPhase_q, halfPhase_d;
    logic [12:0] subPeriod;
    logic        genRun, subTick;

    // IR uses divisor bits 12..1 at twice the tick rate for 1/32 pulses
    always_comb begin
        if (cfg_q.irOn) begin
            subPeriod = {1'b0, cfg_q.baudDivisor[12:1]}; // see [R2] [R8]
        end else begin
            subPeriod = cfg_q.baudDivisor; // see [R1]
        end
        genRun      = started_q && subPeriod != '0; // see [R3] [R4]
        subTick     = genRun && baudCnt_q + 13'h0001 >= subPeriod;
        baudCnt_d   = baudCnt_q;
        halfPhase_d = halfPhase_q;
        started_d   = started_q || txEn || rxEn; // see [R3]
        if (!genRun) begin
            baudCnt_d   = '0;
            halfPhase_d = 1'b0;
        end else if (subTick) begin
            baudCnt_d   = '0;
            halfPhase_d = !halfPhase_q;
        end else begin
            baudCnt_d   = baudCnt_q + 13'h0001;
        end
        // Normal: every sub-tick; IR: every second one
        sampleTick = subTick && (!cfg_q.irOn || halfPhase_q); // see [R17]
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            baudCnt_q   <= '0;
            halfPhase_q <= 1'b0;
            started_q   <= 1'b0;
        end else begin
            baudCnt_q   <= baudCnt_d;
            halfPhase_q <= halfPhase_d;
            started_q   <= started_d;
        end
    end

    // Two-entry transmit buffer between the data register and shifter
    logic [7:0] bufMem_q [2];
    logic [7:0] bufMem_d [2];
    logic       bufWr_q, bufWr_d, bufRd_q, bufRd_d;
    logic [1:0] bufCnt_q, bufCnt_d;
    logic       bufPush, bufPop, bufOutValid;

    assign bufInReady  = bufCnt_q != 2'd2;
    assign bufOutValid = bufCnt_q != 2'd0;
    assign bufPush     = wrEn && address == IDX_DATA && bufInReady;

    always_comb begin
        bufMem_d = bufMem_q;
        bufWr_d  = bufWr_q;
        bufRd_d  = bufRd_q;
        bufCnt_d = bufCnt_q;
        if (bufPush) begin
            bufMem_d[bufWr_q] = writedata[7:0];
            bufWr_d = !bufWr_q;
        end
        if (bufPop) begin
            bufRd_d = !bufRd_q;
        end
        bufCnt_d = bufCnt_q + {1'b0, bufPush} - {1'b0, bufPop};
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bufMem_q[0] <= RST_ZERO;
            bufMem_q[1] <= RST_ZERO;
            bufWr_q     <= 1'b0;
            bufRd_q     <= 1'b0;
            bufCnt_q    <= '0;
        end else begin
            bufMem_q <= bufMem_d;
            bufWr_q  <= bufWr_d;
            bufRd_q  <= bufRd_d;
            bufCnt_q <= bufCnt_d;
        end
    end

    // Transmitter: frame walked in sub-ticks
    asbir_tx_state_type txState_q, txState_d;
    logic [9:0] txShift_q, txShift_d;
    logic [3:0] txBit_q, txBit_d;
    logic [5:0] txPhase_q, txPhase_d;
    logic       txOut_q, txOut_d;
    logic [5:0] subsPerBit;

    assign subsPerBit = cfg_q.irOn ? SUBS_IR : SUBS_NORMAL;
    // A stalled generator keeps the frame waiting; bytes stay buffered
    assign bufPop     = txState_q == TX_IDLE && txEn && bufOutValid
                        && genRun;

    always_comb begin
        txState_d = txState_q;
        txShift_d = txShift_q;
        txBit_d   = txBit_q;
        txPhase_d = txPhase_q;
        txOut_d   = 1'b1; // see [R9]
        case (txState_q)
            TX_IDLE: begin
                if (bufPop) begin
                    txShift_d = {1'b1, bufMem_q[bufRd_q], 1'b0};
                    txBit_d   = '0;
                    txPhase_d = '0;
                    txState_d = TX_SEND;
                end
            end
            TX_SEND: begin
                if (subTick) begin
                    txPhase_d = txPhase_q + 6'h01;
                    if (txPhase_q + 6'h01 == subsPerBit) begin
                        txPhase_d = '0;
                        txShift_d = {1'b1, txShift_q[9:1]};
                        txBit_d   = txBit_q + 4'h1;
                        if (txBit_q == FRAME_BITS) begin
                            txState_d = TX_IDLE;
                        end
                    end
                end
                if (!txEn) begin
                    txState_d = TX_IDLE;
                end
            end
            default: txState_d = TX_IDLE;
        endcase
        // IR zero is a short low pulse at the start of the bit
        if (txState_d == TX_SEND) begin
            if (cfg_q.irOn) begin
                txOut_d = txShift_d[0]
                          || txPhase_d >= pulseWidth(cfg_q.narrowPulseSel);
            end else begin
                txOut_d = txShift_d[0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txState_q <= TX_IDLE;
            txShift_q <= '1;
            txBit_q   <= '0;
            txPhase_q <= '0;
            txOut_q   <= 1'b1;
        end else begin
            txState_q <= txState_d;
            txShift_q <= txShift_d;
            txBit_q   <= txBit_d;
            txPhase_q <= txPhase_d;
            txOut_q   <= txOut_d;
        end
    end

    assign txdOut = txOut_q;
    assign txdOe  = txEn; // see [R10]

    // Receiver, behind a two-stage synchroniser
    asbir_rx_state_type rxState_q, rxState_d;
    logic       rxS1_q, rxS2_q;
    logic [8:0] rxShift_q, rxShift_d;
    logic [3:0] rxBit_q, rxBit_d;
    logic [5:0] rxPhase_q, rxPhase_d;
    logic       rxLow_q, rxLow_d, rxDone;

    always_comb begin
        rxState_d = rxState_q;
        rxShift_d = rxShift_q;
        rxBit_d   = rxBit_q;
        rxPhase_d = rxPhase_q;
        rxLow_d   = rxLow_q;
        rxDone    = 1'b0;
        case (rxState_q)
            RX_IDLE: begin
                // High line is idle; a low starts a frame
                if (rxEn && genRun && !rxS2_q) begin // see [R11]
                    rxState_d = RX_RECV;
                    rxBit_d   = '0;
                    rxPhase_d = '0;
                    rxLow_d   = 1'b0;
                end
            end
            RX_RECV: begin
                if (sampleTick) begin
                    rxPhase_d = rxPhase_q + 6'h01;
                    rxLow_d   = rxLow_q || !rxS2_q;
                    if (!cfg_q.irOn && rxPhase_q == SUB_MID) begin
                        // Mid-bit sample; a high start is a glitch
                        rxShift_d = {rxS2_q, rxShift_q[8:1]};
                        if (rxBit_q == '0 && rxS2_q) begin
                            rxState_d = RX_IDLE;
                        end
                    end
                    if (rxPhase_q + 6'h01 == SUBS_NORMAL) begin
                        // IR: a low seen at any sample tick in the bit reads as zero
                        if (cfg_q.irOn) begin
                            rxShift_d = {!rxLow_d, rxShift_q[8:1]};
                        end
                        rxPhase_d = '0;
                        rxLow_d   = 1'b0;
                        rxBit_d   = rxBit_q + 4'h1;
                        if (rxBit_q == FRAME_BITS) begin
                            rxDone    = 1'b1;
                            rxState_d = RX_IDLE;
                        end
                    end
                end
                if (!rxEn) begin
                    rxState_d = RX_IDLE; // see [R12]
                end
            end
            default: rxState_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxS1_q    <= 1'b1;
            rxS2_q    <= 1'b1;
            rxState_q <= RX_IDLE;
            rxShift_q <= '0;
            rxBit_q   <= '0;
            rxPhase_q <= '0;
            rxLow_q   <= 1'b0;
        end else begin
            rxS1_q    <= rxdIn;
            rxS2_q    <= rxS1_q;
            rxState_q <= rxState_d;
            rxShift_q <= rxShift_d;
            rxBit_q   <= rxBit_d;
            rxPhase_q <= rxPhase_d;
            rxLow_q   <= rxLow_d;
        end
    end

    // Register file; identical in every operating mode, see [R16]
    always_comb begin
        cfg_d      = cfg_q;
        highHold_d = highHold_q;
        frame_d    = frame_q;
        enable_d   = enable_q;
        map_d      = map_q;
        altLine_d  = altLine_q;
        altIrq_d   = altIrq_q;
        altBerr_d  = altBerr_q;
        ninth_d    = ninth_q;
        rxData_d   = rxData_q;
        rxFull_d   = rxFull_q;
        ack_d      = (read || (write && !dataBlocked)) && !ack_q;
        rdata_d    = rdata_q;
        // Reading received data clears full; a new byte wins
        if (rdEn && address == IDX_DATA) begin
            rxFull_d = 1'b0;
        end
        if (rxDone) begin
            rxData_d = cfg_q.irOn ? rxShift_q[8:1] : rxShift_q[7:0];
            rxFull_d = 1'b1;
        end
        if (wrEn) begin
            case (address)
                IDX_BAUD_HIGH: begin
                    if (altMap) begin
                        altLine_d = writedata[7:0] & MASK_ALT_LINE; // see [R14]
                    end else begin
                        highHold_d = writedata[7:0]; // see [R5]
                    end
                end
                IDX_BAUD_LOW: begin
                    if (altMap) begin
                        altIrq_d = writedata[7:0] & MASK_ALT_IRQ;
                    end else begin
                        // Commit held high byte with the low byte
                        cfg_d = {highHold_q, writedata[7:0]}; // see [R5] [R6]
                    end
                end
                IDX_FRAME: begin
                    if (altMap) begin
                        altBerr_d = writedata[7:0] & MASK_ALT_BERR;
                    end else begin
                        frame_d = writedata[7:0];
                    end
                end
                IDX_ENABLE: enable_d = writedata[7:0];
                IDX_MAP:    map_d    = writedata[7:0] & MASK_MAP; // see [R13]
                IDX_NINTH:  ninth_d  = writedata[7:0] & MASK_NINTH;
                default: ;
            endcase
        end
        // Read data latched on accept, stands at the completing edge
        if (ack_d) begin
            rdata_d = '0; // see [R13]
            case (address)
                IDX_BAUD_HIGH: rdata_d[7:0] = altMap ? altLine_q
                                              : cfg_q[15:8];
                IDX_BAUD_LOW:  rdata_d[7:0] = altMap ? altIrq_q
                                              : cfg_q[7:0];
                IDX_FRAME:     rdata_d[7:0] = altMap ? altBerr_q : frame_q;
                IDX_ENABLE:    rdata_d[7:0] = enable_q;
                IDX_EVENT: begin
                    rdata_d[BIT_TX_EMPTY] = bufInReady;
                    rdata_d[BIT_TX_DONE]  = !bufOutValid
                                            && txState_q == TX_IDLE;
                    rdata_d[BIT_RX_FULL]  = rxFull_q;
                end
                IDX_MAP: begin
                    rdata_d[7:0]         = map_q;
                    rdata_d[BIT_RX_BUSY] = rxState_q == RX_RECV;
                end
                IDX_NINTH:     rdata_d[7:0] = ninth_q;
                default:       rdata_d[7:0] = rxData_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q      <= {RST_BAUD_HIGH, RST_BAUD_LOW};
            highHold_q <= RST_BAUD_HIGH;
            frame_q    <= RST_ZERO;
            enable_q   <= RST_ZERO;
            map_q      <= RST_ZERO; // see [R15]
            altLine_q  <= RST_ZERO;
            altIrq_q   <= RST_ZERO;
            altBerr_q  <= RST_ZERO;
            ninth_q    <= RST_ZERO;
            rxData_q   <= RST_ZERO;
            rxFull_q   <= 1'b0;
            ack_q      <= 1'b0;
            rdata_q    <= '0;
        end else begin
            cfg_q      <= cfg_d;
            highHold_q <= highHold_d;
            frame_q    <= frame_d;
            enable_q   <= enable_d;
            map_q      <= map_d;
            altLine_q  <= altLine_d;
            altIrq_q   <= altIrq_d;
            altBerr_q  <= altBerr_d;
            ninth_q    <= ninth_d;
            rxData_q   <= rxData_d;
            rxFull_q   <= rxFull_d;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
        end
    end

    // Checks
    a_gen_not_started: assert property (@(posedge clk_sys) // see [R3]
        disable iff (!reset_n) !started_q |-> !subTick)
        else $error("baud tick before first enable");
    a_gen_zero_held: assert property (@(posedge clk_sys) // see [R4]
        disable iff (!reset_n) subPeriod == '0 |-> !subTick && !sampleTick)
        else $error("baud tick with zero divisor");
    a_normal_tick: assert property (@(posedge clk_sys) // see [R1]
        disable iff (!reset_n)
        subTick && !cfg_q.irOn |-> sampleTick
        && baudCnt_q + 13'h0001 == subPeriod)
        else $error("normal tick not at divisor");
    a_ir_half_tick: assert property (@(posedge clk_sys) // see [R2]
        disable iff (!reset_n)
        subTick && cfg_q.irOn |-> sampleTick == halfPhase_q)
        else $error("ir tick not every second sub tick");
    a_high_held: assert property (@(posedge clk_sys) // see [R5]
        disable iff (!reset_n)
        wrEn && address == IDX_BAUD_HIGH |=> $stable(cfg_q))
        else $error("high byte took effect early");
    a_ir_pulse: assert property (@(posedge clk_sys) // see [R7]
        disable iff (!reset_n)
        $past(txState_d) == TX_SEND && cfg_q.irOn && !txdOut
        && $stable(cfg_q)
        |-> $past(txPhase_d) < pulseWidth(cfg_q.narrowPulseSel))
        else $error("ir pulse too wide");
    a_txd_idle_high: assert property (@(posedge clk_sys) // see [R9]
        disable iff (!reset_n)
        txState_q == TX_IDLE && $past(txState_q) == TX_IDLE |-> txdOut)
        else $error("idle transmit line not high");
    a_txd_released: assert property (@(posedge clk_sys) // see [R10]
        disable iff (!reset_n) !txEn |-> !txdOe)
        else $error("transmit driven while disabled");
    a_rx_ignored: assert property (@(posedge clk_sys) // see [R12]
        disable iff (!reset_n) !rxEn |=> rxState_q == RX_IDLE)
        else $error("receiver active while disabled");
    a_reserved_zero: assert property (@(posedge clk_sys) // see [R13]
        disable iff (!reset_n) rdEn |-> readdata[31:8] == '0)
        else $error("upper read bits not zero");
    a_alt_decode: assert property (@(posedge clk_sys) // see [R14]
        disable iff (!reset_n)
        wrEn && altMap && address <= IDX_FRAME |=> $stable(cfg_q)
        && $stable(frame_q))
        else $error("alternate map wrote primary register");

endmodule

// ### hdl/asbir_pkg.sv
// What this block does
// [R1] Infrared off: baud is clock over sixteen times the 13-bit divisor.
// [R2] Infrared on: baud is clock over 32 times divisor bits 12..1.
// [R3] Baud generator stays stopped until transmitter or receiver first enabled.
// [R4] Generator held off while the effective divisor is zero.
// [R5] High divisor byte waits in holding until the low byte is written.
// [R6] Divisor readback may show old value until low byte is written.
// [R7] Pulse select 11=1/4, 10=1/32, 01=1/16, 00=3/16 of a bit.
// [R8] High divisor bit 7 switches the infrared path on or off.
// [R9] Transmit line rests high when idle, both formats.
// [R10] Transmit output released whenever the transmitter is disabled.
// [R11] Receiver takes a steady high receive line as idle.
// [R12] Receive line ignored while the receiver is disabled.
// [R13] Reserved locations and bits ignore writes and read zero.
// [R14] Alternate-map bit swaps offsets 0 to 2 onto the alternate registers.
// [R15] Alternate-map bit is zero after reset.
// [R16] Same behaviour in all operating modes; only wait and stop low power.
// [R17] Generator gives a tick at sixteen times bit rate for the receiver.
package asbir_pkg;

    localparam logic [2:0] IDX_BAUD_HIGH = 3'h0; // Also alt line status
    localparam logic [2:0] IDX_BAUD_LOW  = 3'h1; // Also alt irq enables
    localparam logic [2:0] IDX_FRAME     = 3'h2; // Also alt bit error ctl
    localparam logic [2:0] IDX_ENABLE    = 3'h3;
    localparam logic [2:0] IDX_EVENT     = 3'h4;
    localparam logic [2:0] IDX_MAP       = 3'h5;
    localparam logic [2:0] IDX_NINTH     = 3'h6;
    localparam logic [2:0] IDX_DATA      = 3'h7;

    // Writable bit masks; everything else is reserved
    localparam logic [7:0] MASK_ALT_LINE = 8'h87;
    localparam logic [7:0] MASK_ALT_IRQ  = 8'h83;
    localparam logic [7:0] MASK_ALT_BERR = 8'h07;
    localparam logic [7:0] MASK_MAP      = 8'h9E;
    localparam logic [7:0] MASK_NINTH    = 8'h40;

    // Field positions
    localparam int BIT_IR_ON    = 7;
    localparam int BIT_TX_EN    = 3;
    localparam int BIT_RX_EN    = 2;
    localparam int BIT_ALT_MAP  = 7;
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_TX_DONE  = 6;
    localparam int BIT_RX_FULL  = 5;
    localparam int BIT_RX_BUSY  = 0;

    localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
    localparam logic [7:0] RST_BAUD_LOW  = 8'h04;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // Sub-ticks per bit: 16 normal, 32 infrared (one sub-tick = 1/32)
    localparam logic [5:0] SUBS_NORMAL = 6'h10;
    localparam logic [5:0] SUBS_IR     = 6'h20;
    localparam logic [5:0] SUB_MID     = 6'h07;
    localparam logic [3:0] FRAME_BITS  = 4'h9; // Stop bit index: start, 8 data, stop
    localparam logic [5:0] PULSE_1_4   = 6'h08;
    localparam logic [5:0] PULSE_1_32  = 6'h01;
    localparam logic [5:0] PULSE_1_16  = 6'h02;
    localparam logic [5:0] PULSE_3_16  = 6'h06;

    typedef struct packed {
        logic        irOn;            // infrared_on
        logic [1:0]  narrowPulseSel;  // narrow_pulse_sel
        logic [12:0] baudDivisor;     // baud_divisor
    } asbir_baud_cfg_type;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND} asbir_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_RECV} asbir_rx_state_type;

endpackage

// ### tb/asbir_peer.sv
`timescale 1ns/1ps
// Far-side serial port: 8N1, LSB first
module asbir_peer (
    input  wire logic clk_sys, // Clock used for pacing only
    input  wire logic txdPin,  // Resolved transmit pin
    output logic      rxdIn    // Line driven towards the block
);
    // Rests high between frames
    initial rxdIn = 1'b1;
    // Whole frame, changes just after rising edges
    task automatic send(input logic [7:0] b, input int bitClk);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxdIn <= f[i];
            repeat (bitClk) @(posedge clk_sys);
        end
    endtask
    // Mid-bit sampling, stop bit not checked
    task automatic recv(output logic [7:0] b, input int bitClk);
        do @(negedge clk_sys); while (txdPin !== 1'b1); // Past prior frame
        do @(negedge clk_sys); while (txdPin !== 1'b0);
        repeat (bitClk / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bitClk) @(negedge clk_sys);
            b[i] = txdPin;
        end
    endtask
endmodule

// ### tb/asbir_front_tb_top.sv
`timescale 1ns/1ps
module asbir_front_tb_top;
    import asbir_pkg::*;
    logic        clk_sys, reset_n, read, write, rxdIn;
    logic        waitrequest, txdOut, txdOe, sampleTick;
    logic [2:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata;
    logic [7:0]  q, b, r;
    logic [7:0]  tx [4];
    logic [12:0] d;
    int          n, errTotal, totalChecks;
    wire         txdPin = txdOe ? txdOut : 1'b1; // Pulled up when released

    asbir_front dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rxdIn(rxdIn),
        .txdOut(txdOut), .txdOe(txdOe), .sampleTick(sampleTick));
    asbir_peer peer (.clk_sys(clk_sys), .txdPin(txdPin), .rxdIn(rxdIn));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Avalon access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [7:0] v, output logic [7:0] rd);
        @(posedge clk_sys);
        address <= a;
        writedata <= {24'h00_0000, v};
        byteenable <= 4'h1;
        write <= w;
        read <= !w;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic tick_count(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (sampleTick === 1'b1) c++;
        end
    endtask

    // Third gap measured, first may straddle a divisor change
    task automatic tick_gap(output int c);
        repeat (2) begin
            c = 0;
            do @(negedge clk_sys); while (sampleTick !== 1'b1);
            do begin
                @(negedge clk_sys);
                c++;
            end while (sampleTick !== 1'b1 && c < 200);
        end
    endtask

    task automatic tx_wait();
        for (int i = 0; i < 500; i++) begin
            bus(1'b0, IDX_EVENT, 8'h00, q);
            if (q[BIT_TX_DONE]) break;
        end
    endtask

    function automatic logic [7:0] div_gap(input logic ir,
                                           input logic [12:0] dv);
        return ir ? 8'({dv[12:1], 1'b0}) : 8'(dv);
    endfunction

    function automatic logic [7:0] ir_width(input logic [1:0] s);
        return (s == 2'h3) ? 8'h08 : (s == 2'h2) ? 8'h01 :
               (s == 2'h1) ? 8'h02 : 8'h06;
    endfunction

    // Hang guard, far above the few thousand cycles needed
    initial begin
        repeat (60000) @(posedge clk_sys);
        errTotal++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        {read, write, address, byteenable, writedata} = '0;
        errTotal = 0;
        totalChecks = 0;
        void'($urandom(32'h1fec_60b1));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk({7'h00, txdOe}, 8'h00);
        chk({7'h00, txdPin}, 8'h01);
        bus(1'b0, IDX_BAUD_HIGH, 8'h00, q);
        chk(q, RST_BAUD_HIGH);
        bus(1'b0, IDX_MAP, 8'h00, q);
        chk(q, RST_ZERO);
        tick_count(100, n);
        chk(8'(n), 8'h00);
        // High byte alone stays in holding
        bus(1'b1, IDX_BAUD_HIGH, 8'h01, q);
        bus(1'b0, IDX_BAUD_HIGH, 8'h00, q);
        chk(q, 8'h00);
        bus(1'b1, IDX_BAUD_LOW, 8'h00, q);
        bus(1'b0, IDX_BAUD_HIGH, 8'h00, q);
        chk(q, 8'h01);
        // Zero effective divisor in both modes keeps generator off
        bus(1'b1, IDX_BAUD_HIGH, 8'h00, q);
        bus(1'b1, IDX_BAUD_LOW, 8'h00, q);
        bus(1'b1, IDX_ENABLE, 8'h0C, q);
        tick_count(100, n);
        chk(8'(n), 8'h00);
        chk({7'h00, txdOe}, 8'h01);
        bus(1'b1, IDX_BAUD_HIGH, 8'h80, q);
        bus(1'b1, IDX_BAUD_LOW, 8'h01, q);
        tick_count(100, n);
        chk(8'(n), 8'h00);
        // Random divisors, infrared alternating
        for (int k = 0; k < 6; k++) begin
            d = 13'($urandom_range(2, 40));
            bus(1'b1, IDX_BAUD_HIGH, {k[0], 2'h0, d[12:8]}, q);
            bus(1'b1, IDX_BAUD_LOW, d[7:0], q);
            tick_gap(n);
            chk(8'(n), div_gap(k[0], d));
        end
        // Every pulse width, one clock per thirty-second of a bit
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, IDX_BAUD_HIGH, {1'b1, 2'(s), 5'h00}, q);
            bus(1'b1, IDX_BAUD_LOW, 8'h02, q);
            bus(1'b1, IDX_DATA, 8'h00, q);
            do @(negedge clk_sys); while (txdPin !== 1'b0);
            n = 0;
            while (txdPin === 1'b0 && n < 100) begin
                n++;
                @(negedge clk_sys);
            end
            chk(8'(n), ir_width(2'(s)));
            tx_wait();
        end
        // Normal format, 32 clocks a bit; fourth write stalls on full buffer
        bus(1'b1, IDX_BAUD_HIGH, 8'h00, q);
        bus(1'b1, IDX_BAUD_LOW, 8'h02, q);
        foreach (tx[i]) tx[i] = 8'($urandom);
        fork
            foreach (tx[i]) bus(1'b1, IDX_DATA, tx[i], q);
            for (int i = 0; i < 4; i++) begin
                peer.recv(r, 32);
                chk(r, tx[i]);
            end
        join
        tx_wait();
        chk({7'h00, txdPin}, 8'h01);
        bus(1'b0, IDX_MAP, 8'h00, q);
        chk({7'h00, q[BIT_RX_BUSY]}, 8'h00);
        b = 8'($urandom);
        peer.send(b, 32);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, IDX_DATA, 8'h00, q);
        chk(q, b);
        // Receiver off: a whole frame on the line is ignored
        bus(1'b1, IDX_ENABLE, 8'h08, q);
        peer.send(~b, 32);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, IDX_EVENT, 8'h00, q);
        chk({7'h00, q[BIT_RX_FULL]}, 8'h00);
        // Alternate map, reserved bits read zero
        bus(1'b1, IDX_MAP, 8'h80, q);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 3'(i), 8'hFF, q);
            bus(1'b0, 3'(i), 8'h00, q);
            chk(q, i == 0 ? MASK_ALT_LINE :
                i == 1 ? MASK_ALT_IRQ : MASK_ALT_BERR);
        end
        bus(1'b1, IDX_NINTH, 8'hFF, q);
        bus(1'b0, IDX_NINTH, 8'h00, q);
        chk(q, MASK_NINTH);
        bus(1'b1, IDX_MAP, 8'h00, q);
        bus(1'b0, IDX_BAUD_LOW, 8'h00, q);
        chk(q, 8'h02);
        bus(1'b1, IDX_ENABLE, 8'h00, q);
        @(negedge clk_sys);
        chk({7'h00, txdOe}, 8'h00);
        report_and_stop();
    end
endmodule
